// *** hdl/lpbp_map.vh ***
`ifndef LPBP_MAP_VH
`define LPBP_MAP_VH

// Management addressing
`define LPBP_DEVAD         5'h07
`define LPBP_ADDR_LOW      16'h0205
`define LPBP_ADDR_MID      16'h0206
`define LPBP_ADDR_HIGH     16'h0207
`define LPBP_ADDR_STEP     16'h0001
`define LPBP_ADDR_RST      16'h0000
`define LPBP_WORD_RST      16'h0000
`define LPBP_PHY_ADDR_DEF  5'h00

// Middle word bit positions
`define LPBP_MID_LONG      14
`define LPBP_MID_GIGA      7
`define LPBP_MID_SRFD      6
`define LPBP_MID_HUND      5
`define LPBP_MID_LEAD      4

// High word bit positions
`define LPBP_HIGH_EEE      14
`define LPBP_HIGH_ABLE     13
`define LPBP_HIGH_REQ      12
`define LPBP_HIGH_SRHD     11

// Frame fields within the 14-bit header
`define LPBP_HDR_ST        13:12
`define LPBP_HDR_OP        11:10
`define LPBP_HDR_PRT       9:5
`define LPBP_HDR_DEV       4:0
`define LPBP_HDR_RST       13'h0000

// Frame codes
`define LPBP_ST_C45        2'h0
`define LPBP_OP_ADDR       2'h0
`define LPBP_OP_WRITE      2'h1
`define LPBP_OP_PRINC      2'h2
`define LPBP_OP_READ       2'h3

// Frame bit counts
`define LPBP_PRE_LEN       6'h20
`define LPBP_PRE_RST       6'h00
`define LPBP_PRE_STEP      6'h01
`define LPBP_CNT_RST       5'h00
`define LPBP_CNT_STEP      5'h01
`define LPBP_HDR_FIRST     5'h01
`define LPBP_HDR_LAST      5'h0D
`define LPBP_TA_LAST       5'h01
`define LPBP_DATA_LAST     5'h0F

`endif

// *** hdl/lpbp_snap.v ***
`timescale 1ns/1ps
`include "lpbp_map.vh"

module lpbp_snap (
  input  wire        clk,
  input  wire        rst,
  input  wire        snapTrig,
  input  wire        partnerLongReachAbility,
  input  wire        partnerGigabitAbility,
  input  wire        partnerShortReachFullDuplex,
  input  wire        partnerHundredMegAbility,
  input  wire        partnerLeaderSelect,
  input  wire        partnerLeaderForced,
  input  wire        partnerEnergyEfficientAbility,
  input  wire        partnerHighLevelAble,
  input  wire        partnerHighLevelRequest,
  input  wire        partnerShortReachHalfDuplex,
  output reg  [15:0] midWord_q,
  output reg  [15:0] highWord_q,
  output reg         leaderForced_q
);

  reg [15:0] midLive;
  reg [15:0] highLive;

  // Live words, reserved bits held at zero
  always @* begin
    midLive                    = `LPBP_WORD_RST;                // [R16]
    midLive[`LPBP_MID_LONG]    = partnerLongReachAbility;       // [R04]
    midLive[`LPBP_MID_GIGA]    = partnerGigabitAbility;         // [R05]
    midLive[`LPBP_MID_SRFD]    = partnerShortReachFullDuplex;   // [R06]
    midLive[`LPBP_MID_HUND]    = partnerHundredMegAbility;      // [R07]
    midLive[`LPBP_MID_LEAD]    = partnerLeaderSelect;           // [R08]
    highLive                   = `LPBP_WORD_RST;                // [R16]
    highLive[`LPBP_HIGH_EEE]   = partnerEnergyEfficientAbility; // [R10]
    highLive[`LPBP_HIGH_ABLE]  = partnerHighLevelAble;          // [R11]
    highLive[`LPBP_HIGH_REQ]   = partnerHighLevelRequest;       // [R12]
    highLive[`LPBP_HIGH_SRHD]  = partnerShortReachHalfDuplex;   // [R13]
  end

  // Snapshot taken only on a low word read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      midWord_q      <= `LPBP_WORD_RST; // [R01]
      highWord_q     <= `LPBP_WORD_RST; // [R01]
      leaderForced_q <= 1'b0;
    end else if (snapTrig) begin
      midWord_q      <= midLive;             // [R02]
      highWord_q     <= highLive;            // [R02]
      leaderForced_q <= partnerLeaderForced; // [R09]
    end
  end

endmodule // lpbp_snap

// *** hdl/lpbp_mdio_regs.v ***
`timescale 1ns/1ps
`include "lpbp_map.vh"

// Contract
// R01 - Middle/high words at 0x0206/0x0207, reset zero
// R02 - Snapshot both words on low word read
// R03 - Reads return snapshot, never live page
// R04 - Middle bit 14: long-reach 10M ability
// R05 - Middle bit 7: gigabit ability
// R06 - Middle bit 6: short-reach full duplex
// R07 - Middle bit 5: hundred-meg ability
// R08 - Middle bit 4: leader one, follower zero
// R09 - Forced bit qualifies leader bit meaning
// R10 - High bit 14: energy-efficient ability
// R11 - High bit 13: high-level transmit able
// R12 - High bit 12: high-level transmit requested
// R13 - High bit 11: short-reach half duplex
// R14 - Low word read triggers both snapshots
// R15 - Low level unless both able; else request
// R16 - Reserved bits zero, writes ignored
module lpbp_mdio_regs #(
  parameter [4:0] PHY_ADDR = `LPBP_PHY_ADDR_DEF
) (
  input  wire clk,
  input  wire rst,
  input  wire mdc,
  input  wire mdioIn,
  output reg  mdioOut_q,
  output reg  mdioOe_q,
  input  wire partnerLongReachAbility,
  input  wire partnerGigabitAbility,
  input  wire partnerShortReachFullDuplex,
  input  wire partnerHundredMegAbility,
  input  wire partnerLeaderSelect,
  input  wire partnerLeaderForced,
  input  wire partnerEnergyEfficientAbility,
  input  wire partnerHighLevelAble,
  input  wire partnerHighLevelRequest,
  input  wire partnerShortReachHalfDuplex,
  input  wire localHighLevelAble,
  input  wire localHighLevelRequest,
  output wire partnerLeaderSelect_q,
  output wire partnerLeaderForced_q,
  output reg  highLevelSel_q
);

  localparam [1:0] ST_PRE  = 2'h0;
  localparam [1:0] ST_HDR  = 2'h1;
  localparam [1:0] ST_TA   = 2'h2;
  localparam [1:0] ST_DATA = 2'h3;

  reg  [1:0]  state_q;
  reg         mdcPrev_q;
  reg  [5:0]  onesCnt_q;
  reg  [4:0]  bitCnt_q;
  reg  [12:0] hdr_q;
  reg  [1:0]  op_q;
  reg         hit_q;
  reg         drive_q;
  reg  [15:0] txShift_q;
  reg  [15:0] rxShift_q;
  reg  [15:0] addr_q;
  reg         snapTrig_q;
  reg  [15:0] rdData;

  wire [15:0] midWord;
  wire [15:0] highWord;
  wire        mdcRise;
  wire [13:0] hdrFull;
  wire        hdrHit;
  wire        hdrRead;
  wire        ownAddr;

  assign mdcRise = mdc & ~mdcPrev_q;
  assign hdrFull = {hdr_q, mdioIn};
  assign hdrHit  = (hdrFull[`LPBP_HDR_ST] == `LPBP_ST_C45) &&
                   (hdrFull[`LPBP_HDR_PRT] == PHY_ADDR) &&
                   (hdrFull[`LPBP_HDR_DEV] == `LPBP_DEVAD);
  assign hdrRead = (hdrFull[`LPBP_HDR_OP] == `LPBP_OP_READ) ||
                   (hdrFull[`LPBP_HDR_OP] == `LPBP_OP_PRINC);
  assign ownAddr = (addr_q == `LPBP_ADDR_MID) || (addr_q == `LPBP_ADDR_HIGH);

  assign partnerLeaderSelect_q = midWord[`LPBP_MID_LEAD];

  // Read mux over snapshot words only
  always @* begin
    case (addr_q)
      `LPBP_ADDR_MID:  rdData = midWord;  // [R03]
      `LPBP_ADDR_HIGH: rdData = highWord; // [R03]
      default:         rdData = `LPBP_WORD_RST;
    endcase
  end

  lpbp_snap uSnap (
    .clk                           (clk),
    .rst                           (rst),
    .snapTrig                      (snapTrig_q),
    .partnerLongReachAbility       (partnerLongReachAbility),
    .partnerGigabitAbility         (partnerGigabitAbility),
    .partnerShortReachFullDuplex   (partnerShortReachFullDuplex),
    .partnerHundredMegAbility      (partnerHundredMegAbility),
    .partnerLeaderSelect           (partnerLeaderSelect),
    .partnerLeaderForced           (partnerLeaderForced),
    .partnerEnergyEfficientAbility (partnerEnergyEfficientAbility),
    .partnerHighLevelAble          (partnerHighLevelAble),
    .partnerHighLevelRequest       (partnerHighLevelRequest),
    .partnerShortReachHalfDuplex   (partnerShortReachHalfDuplex),
    .midWord_q                     (midWord),
    .highWord_q                    (highWord),
    .leaderForced_q                (partnerLeaderForced_q)
  );

  // Transmit level resolution
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      highLevelSel_q <= 1'b0;
    end else begin
      highLevelSel_q <= localHighLevelAble & partnerHighLevelAble &
                        (localHighLevelRequest | partnerHighLevelRequest); // [R15]
    end
  end

  // Management frame engine
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_PRE;
      mdcPrev_q  <= 1'b0;
      onesCnt_q  <= `LPBP_PRE_RST;
      bitCnt_q   <= `LPBP_CNT_RST;
      hdr_q      <= `LPBP_HDR_RST;
      op_q       <= `LPBP_OP_ADDR;
      hit_q      <= 1'b0;
      drive_q    <= 1'b0;
      txShift_q  <= `LPBP_WORD_RST;
      rxShift_q  <= `LPBP_WORD_RST;
      addr_q     <= `LPBP_ADDR_RST;
      snapTrig_q <= 1'b0;
      mdioOut_q  <= 1'b0;
      mdioOe_q   <= 1'b0;
    end else begin
      mdcPrev_q  <= mdc;
      snapTrig_q <= 1'b0;
      if (mdcRise) begin
        case (state_q)
          ST_PRE: begin
            if (mdioIn) begin
              if (onesCnt_q != `LPBP_PRE_LEN) begin
                onesCnt_q <= onesCnt_q + `LPBP_PRE_STEP;
              end
            end else begin
              if (onesCnt_q == `LPBP_PRE_LEN) begin
                state_q  <= ST_HDR;
                bitCnt_q <= `LPBP_HDR_FIRST;
                hdr_q    <= `LPBP_HDR_RST;
              end
              onesCnt_q <= `LPBP_PRE_RST;
            end
          end
          ST_HDR: begin
            if (bitCnt_q == `LPBP_HDR_LAST) begin
              state_q  <= ST_TA;
              bitCnt_q <= `LPBP_CNT_RST;
              op_q     <= hdrFull[`LPBP_HDR_OP];
              hit_q    <= hdrHit;
              drive_q  <= hdrHit & hdrRead & ownAddr;
              txShift_q <= rdData; // [R03]
              if (hdrHit && hdrRead && (addr_q == `LPBP_ADDR_LOW)) begin
                snapTrig_q <= 1'b1; // [R14]
              end
            end else begin
              hdr_q    <= {hdr_q[11:0], mdioIn};
              bitCnt_q <= bitCnt_q + `LPBP_CNT_STEP;
            end
          end
          ST_TA: begin
            if (bitCnt_q == `LPBP_TA_LAST) begin
              state_q  <= ST_DATA;
              bitCnt_q <= `LPBP_CNT_RST;
              if (drive_q) begin
                mdioOut_q <= txShift_q[15];
                txShift_q <= {txShift_q[14:0], 1'b0};
              end
            end else begin
              bitCnt_q <= bitCnt_q + `LPBP_CNT_STEP;
              if (drive_q) begin
                mdioOe_q  <= 1'b1;
                mdioOut_q <= 1'b0;
              end
            end
          end
          ST_DATA: begin
            rxShift_q <= {rxShift_q[14:0], mdioIn};
            if (bitCnt_q == `LPBP_DATA_LAST) begin
              state_q   <= ST_PRE;
              bitCnt_q  <= `LPBP_CNT_RST;
              onesCnt_q <= `LPBP_PRE_RST;
              drive_q   <= 1'b0;
              mdioOe_q  <= 1'b0;
              mdioOut_q <= 1'b0;
              if (hit_q) begin
                case (op_q)
                  `LPBP_OP_ADDR:  addr_q <= {rxShift_q[14:0], mdioIn};
                  `LPBP_OP_PRINC: addr_q <= addr_q + `LPBP_ADDR_STEP;
                  default:        addr_q <= addr_q; // [R16]
                endcase
              end
            end else begin
              bitCnt_q <= bitCnt_q + `LPBP_CNT_STEP;
              if (drive_q) begin
                mdioOut_q <= txShift_q[15];
                txShift_q <= {txShift_q[14:0], 1'b0};
              end
            end
          end
          default: begin
            state_q <= ST_PRE;
          end
        endcase
      end
    end
  end

endmodule // lpbp_mdio_regs

// *** verification/lpbp_mdio_regs_monitor.sv ***
`timescale 1ns/1ps
module lpbp_mdio_regs_monitor (
  input wire clk,
  input wire rst,
  input wire mdc,
  input wire mdioOut_q,
  input wire mdioOe_q,
  input wire partnerHighLevelAble,
  input wire partnerHighLevelRequest,
  input wire localHighLevelAble,
  input wire localHighLevelRequest,
  input wire partnerLeaderSelect_q,
  input wire highLevelSel_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire bothAble = partnerHighLevelAble && localHighLevelAble;
  wire anyReq   = partnerHighLevelRequest || localHighLevelRequest;
  a_sel_low_level: assert property (!rst && !bothAble |=> !highLevelSel_q)
    else $error("level not low without ability");
  a_sel_high_req: assert property (!rst && bothAble && anyReq |=> highLevelSel_q)
    else $error("level not high on request");
  a_sel_no_req: assert property (!rst && bothAble && !anyReq |=> !highLevelSel_q)
    else $error("level high without request");
  a_oe_rise_mdc: assert property ($rose(mdioOe_q) |-> $past(mdc) && !$past(mdc, 2))
    else $error("drive began off an mdc rise");
  a_oe_fall_mdc: assert property ($fell(mdioOe_q) |-> $past(mdc) && !$past(mdc, 2))
    else $error("drive ended off an mdc rise");
  a_oe_first_zero: assert property ($rose(mdioOe_q) |-> !mdioOut_q)
    else $error("first turnaround bit not zero");
  a_out_at_rise: assert property (!$stable(mdioOut_q) |-> $past(mdc) && !$past(mdc, 2))
    else $error("data changed off an mdc rise");
  a_out_idle_low: assert property (!mdioOe_q |-> !mdioOut_q)
    else $error("drive value set while released");
  a_lead_quiet: assert property (!$stable(partnerLeaderSelect_q) |-> !mdioOe_q)
    else $error("snapshot moved during a driven read");
endmodule // lpbp_mdio_regs_monitor

bind lpbp_mdio_regs lpbp_mdio_regs_monitor mon_u (.clk(clk), .rst(rst), .mdc(mdc), .mdioOut_q(mdioOut_q),
  .mdioOe_q(mdioOe_q), .partnerHighLevelAble(partnerHighLevelAble), .partnerHighLevelRequest(partnerHighLevelRequest),
  .localHighLevelAble(localHighLevelAble), .localHighLevelRequest(localHighLevelRequest),
  .partnerLeaderSelect_q(partnerLeaderSelect_q), .highLevelSel_q(highLevelSel_q));

// *** verification/lpbp_host.sv ***
`timescale 1ns/1ps
module lpbp_host (
  input  wire  clk,
  input  wire  mdioWire,
  output logic mdc,
  output logic mdioDrv,
  output logic mdioDrvOe
);
  initial begin
    mdc = 1'h0;
    mdioDrv = 1'h1;
    mdioDrvOe = 1'h0;
  end
  // One bit: data set while mdc low, wire sampled as mdc rises
  task automatic put_bit(input logic b, input logic drv, output logic s);
    @(posedge clk) begin
      mdc <= 1'h0;
      mdioDrv <= b;
      mdioDrvOe <= drv;
    end
    @(posedge clk);
    @(posedge clk) begin
      mdc <= 1'h1;
      s = mdioWire;
    end
    @(posedge clk);
  endtask
  // Whole frame with own preamble; wire released for read turnaround and data
  task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] hd;
    logic        s;
    integer      i;
    hd = {2'h0, op, 5'h00, dev, (op[1] ? 2'h3 : 2'h2), wd};
    rd = 16'h0000;
    for (i = 0; i < 32; i++) put_bit(1'h1, 1'h1, s);
    for (i = 31; i >= 0; i--) begin
      put_bit(hd[i], !(op[1] && i < 18), s);
      if (i < 16) rd[i] = s;
    end
    @(posedge clk) begin
      mdc <= 1'h0;
      mdioDrvOe <= 1'h0;
    end
  endtask
endmodule // lpbp_host

// *** verification/lpbp_mdio_regs_test.sv ***
`timescale 1ns/1ps
module lpbp_mdio_regs_test;
  logic        clk, rst, localAble, localReq;
  logic [9:0]  live;
  logic [15:0] rd;
  logic [44:0] rows [0:3];
  integer      bad_count = 0, tests_run = 0, i;
  wire         mdc, mdioDrv, mdioDrvOe, mdioOut_q, mdioOe_q, leadSel, leadForced, highSel;
  wire         mdioWire = mdioOe_q ? mdioOut_q : (mdioDrvOe ? mdioDrv : 1'h1);
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  lpbp_mdio_regs dut_u (.clk(clk), .rst(rst), .mdc(mdc), .mdioIn(mdioWire), .mdioOut_q(mdioOut_q),
    .mdioOe_q(mdioOe_q), .partnerLongReachAbility(live[9]), .partnerGigabitAbility(live[8]),
    .partnerShortReachFullDuplex(live[7]), .partnerHundredMegAbility(live[6]), .partnerLeaderSelect(live[5]),
    .partnerLeaderForced(live[4]), .partnerEnergyEfficientAbility(live[3]), .partnerHighLevelAble(live[2]),
    .partnerHighLevelRequest(live[1]), .partnerShortReachHalfDuplex(live[0]), .localHighLevelAble(localAble),
    .localHighLevelRequest(localReq), .partnerLeaderSelect_q(leadSel), .partnerLeaderForced_q(leadForced),
    .highLevelSel_q(highSel));
  lpbp_host host_u (.clk(clk), .mdioWire(mdioWire), .mdc(mdc), .mdioDrv(mdioDrv), .mdioDrvOe(mdioDrvOe));
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    host_u.frame(2'h0, 5'h07, a, d);
    host_u.frame(2'h3, 5'h07, 16'h0000, d);
  endtask
  task wrap_up;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #6000000;
    bad_count++;
    wrap_up;
  end
  initial begin
    rst = 1'h1;
    live = 10'h000;
    localAble = 1'h0;
    localReq = 1'h0;
    rows[0] = {10'h3FF, 2'h2, 16'h40F0, 16'h7800, 1'h1};
    rows[1] = {10'h000, 2'h3, 16'h0000, 16'h0000, 1'h0};
    rows[2] = {10'h2A5, 2'h2, 16'h4050, 16'h2800, 1'h0};
    rows[3] = {10'h156, 2'h3, 16'h00A0, 16'h3000, 1'h1};
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rd_reg(16'h0206, rd);
    cmp16(rd, 16'h0000);
    rd_reg(16'h0207, rd);
    cmp16(rd, 16'h0000);
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      @(posedge clk) begin
        live <= rows[i][44:35];
        {localAble, localReq} <= rows[i][34:33];
      end
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp16({15'h0000, highSel}, {15'h0000, rows[i][0]});
      host_u.frame(2'h0, 5'h07, 16'h0205, rd);
      host_u.frame(2'h2, 5'h07, 16'h0000, rd);
      host_u.frame(2'h2, 5'h07, 16'h0000, rd);
      cmp16(rd, rows[i][32:17]);
      host_u.frame(2'h3, 5'h07, 16'h0000, rd);
      cmp16(rd, rows[i][16:1]);
      cmp16({14'h0000, leadSel, leadForced}, {14'h0000, rows[i][40:39]});
      $display("test row %0d done", i);
    end
    @(posedge clk) live <= 10'h3FF;
    rd_reg(16'h0206, rd);
    cmp16(rd, 16'h00A0);
    host_u.frame(2'h1, 5'h07, 16'hFFFF, rd);
    host_u.frame(2'h3, 5'h07, 16'h0000, rd);
    cmp16(rd, 16'h00A0);
    $display("test snapshot hold and write done");
    rd_reg(16'h0208, rd);
    cmp16(rd, 16'hFFFF);
    host_u.frame(2'h0, 5'h07, 16'h0207, rd);
    host_u.frame(2'h3, 5'h01, 16'h0000, rd);
    cmp16(rd, 16'hFFFF);
    $display("test unmapped done");
    @(posedge clk) rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd_reg(16'h0207, rd);
    cmp16(rd, 16'h0000);
    $display("test second reset done");
    wrap_up;
  end
endmodule // lpbp_mdio_regs_test
